/* src/pbr_bridge_cfg.svh */
// Offsets, field positions, reset values and counts for the backplane PIO bridge.
// Assumes inclusion by bare name from the bridge design files.
`ifndef PBR_BRIDGE_CFG_SVH
`define PBR_BRIDGE_CFG_SVH
`define PBR_OFS_UPPER 16'h0004
`define PBR_OFS_LOWER 16'h0008
`define PBR_OFS_XBASE 16'h000C
`define PBR_REG_RST 32'h0000_0000
`define PBR_CMP_HI 31
`define PBR_CMP_LO 16
`define PBR_XB_HI 31
`define PBR_XB_LO 20
`define PBR_WORD_SHIFT 4
`define PBR_LANE_HI 3
`define PBR_LANE_LO 2
`define PBR_LANE_TOP 2'h3
`define PBR_LANE_FIRST 2'h0
`define PBR_OFS_HI 15
`define PBR_ARB_CYCLES 16
`endif

/* src/pbr_pkg.sv */
// Types shared by the backplane PIO bridge, its peer model and its bench.
// Assumes pbr_bridge_cfg.svh is compiled alongside.
package pbr_pkg;
  typedef enum logic [1:0] {PBR_SEL_SETUP, PBR_SEL_WIN_A, PBR_SEL_WIN_B} pbr_sel_e;
  typedef enum {PBR_IDLE, PBR_I_ARB, PBR_I_WAIT, PBR_I_ANS, PBR_T_REQ, PBR_T_XFER,
                PBR_T_DONE} pbr_state_e;
  // Backplane pins seen by this board
  typedef struct packed {
    logic avalid;
    logic write;
    logic gnt;
    logic done_n;
    logic [31:0] addr;
    logic [127:0] data;
  } pbr_bp_in_s;
  // Every registered output of the bridge
  typedef struct packed {
    logic tgt_trdy;
    logic tgt_stop;
    logic [31:0] tgt_rdata;
    logic mst_req;
    logic mst_write;
    logic [31:0] mst_addr;
    logic [63:0] mst_wdata;
    logic dma_halt;
    logic bp_req;
    logic bp_avalid;
    logic bp_write;
    logic [31:0] bp_addr;
    logic [127:0] bp_wdata;
    logic bp_done_n;
    logic bp_done_oe_n;
    logic [127:0] bp_rdata;
  } pbr_out_s;
endpackage : pbr_pkg

/* src/pbr_word_buf.sv */
// One backplane word held as 32-bit lanes, per-lane write enables.
// Assumes a single clock; read word comes out of a register.
`timescale 1ns/1ps
module pbr_word_buf #(
  parameter int LANE_W = 32,
  parameter int LANES = 4
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic [LANES-1:0] i_we,
  input wire logic [LANE_W*LANES-1:0] i_wdata,
  output logic [LANE_W*LANES-1:0] o_word
);
  logic [LANE_W*LANES-1:0] word_d;

  // Merge enabled lanes into the held word
  always_comb begin
    word_d = o_word;
    for (int i = 0; i < LANES; i++) begin
      if (i_we[i]) begin
        word_d[i*LANE_W +: LANE_W] = i_wdata[i*LANE_W +: LANE_W];
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_word <= '0;
    end else begin
      o_word <= word_d;
    end
  end
endmodule : pbr_word_buf

/* src/pbr_bridge.sv */
// Backplane PIO bridge: setup registers, fully coupled initiator and target paths.
// Assumes a simplified local PCI target port, a PCI master port with per-phase acks,
// and backplane pins that arrive asynchronously and are synchronised here.
// What this block does
// - Answer backplane addresses only inside window, comparing top 16 address bits.
// - PCI address bits 31:20 come from inbound translation base.
// - Each backplane address step advances PCI byte address by sixteen.
// - Local PCI cycle stays open until the backplane cycle finishes.
// - Write: store data, win backplane, drive it, give target ready after done.
// - Target write: latch word, win PCI, write it in phases, then done.
// - Read: win backplane, send address, latch returned word, answer 32 bits.
// - Target read: win PCI, read word, place on backplane, signal done.
// - Backplane read only at aligned word; other lanes served from buffer.
// - Narrow window write starts a backplane cycle after one 32-bit write.
// - Full-word window write starts only when the top lane is written.
// - PIO outranks DMA; DMA halted while bridge wants PCI bus.
// - Target side forces running DMA to stop for pending PIO.
// - On window hit request PCI, wait grant, burst two 64-bit phases, then done.
// - No backplane grant within sixteen cycles gives PCI stop for retry.
// - Backplane-originated access beats simultaneous PCI access, which is stopped.
`timescale 1ns/1ps
`include "pbr_bridge_cfg.svh"
module pbr_bridge import pbr_pkg::*; #(
  parameter int ARB_LIMIT = `PBR_ARB_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_tgt_req,
  input wire logic [1:0] i_tgt_sel,
  input wire logic i_tgt_write,
  input wire logic [15:0] i_tgt_addr,
  input wire logic [31:0] i_tgt_wdata,
  output logic o_tgt_trdy,
  output logic o_tgt_stop,
  output logic [31:0] o_tgt_rdata,
  input wire logic [15:0] i_pci_bp_base,
  output logic o_mst_req,
  input wire logic i_mst_gnt,
  output logic o_mst_write,
  output logic [31:0] o_mst_addr,
  output logic [63:0] o_mst_wdata,
  input wire logic [63:0] i_mst_rdata,
  input wire logic i_mst_ack,
  output logic o_dma_halt,
  input wire pbr_bp_in_s i_bp,
  output logic o_bp_req,
  output logic o_bp_avalid,
  output logic o_bp_write,
  output logic [31:0] o_bp_addr,
  output logic [127:0] o_bp_wdata,
  output logic o_bp_done_n,
  output logic o_bp_done_oe_n,
  output logic [127:0] o_bp_rdata
);
  localparam int ARB_LAST = ARB_LIMIT - 1;
  localparam pbr_out_s OUT_RST = '{bp_done_n: 1'b1, bp_done_oe_n: 1'b1, default: '0};

  pbr_bp_in_s bp_s1_q, bp;
  pbr_out_s out_q, out_d;
  pbr_state_e st_q, st_d;
  logic [31:0] upper_q, upper_d, lower_q, lower_d, xbase_q, xbase_d, t_addr_q, t_addr_d;
  logic [4:0] cnt_q, cnt_d;
  logic [1:0] lane_q, lane_d, sel_q, sel_d;
  logic ph_q, ph_d, t_wr_q, t_wr_d, served_q, served_d;
  logic [3:0] mem_we;
  logic [127:0] mem_wdata, mem_word;
  logic bp_hit;

  // Window test, lower inclusive and upper exclusive
  function automatic logic in_window(input logic [31:0] a, lo, hi);
    in_window = (a[`PBR_CMP_HI:`PBR_CMP_LO] >= lo[`PBR_CMP_HI:`PBR_CMP_LO]) &&
                (a[`PBR_CMP_HI:`PBR_CMP_LO] < hi[`PBR_CMP_HI:`PBR_CMP_LO]);
  endfunction : in_window

  // Backplane word address to PCI byte address
  function automatic logic [31:0] to_pci(input logic [31:0] a, lo, xb);
    logic [31:0] ofs;
    ofs = 32'((a - lo) << `PBR_WORD_SHIFT);
    to_pci = {xb[`PBR_XB_HI:`PBR_XB_LO], ofs[`PBR_XB_LO-1:0]};
  endfunction : to_pci

  function automatic logic [31:0] lane_of(input logic [127:0] w, input logic [1:0] l);
    lane_of = w[l*32 +: 32];
  endfunction : lane_of

  pbr_word_buf #(.LANE_W(32), .LANES(4)) u_buf (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_we(mem_we),
    .i_wdata(mem_wdata),
    .o_word(mem_word)
  );

  // Backplane pins cross in through two flops; only the second is read
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      bp_s1_q <= '0;
      bp <= '0;
    end else begin
      bp_s1_q <= i_bp;
      bp <= bp_s1_q;
    end
  end

  // Served flag stops one backplane address from being taken twice
  assign bp_hit = bp.avalid && !served_q && in_window(bp.addr, lower_q, upper_q);

  // Next-state, register and output computation
  always_comb begin
    st_d = st_q;
    out_d = out_q;
    out_d.tgt_trdy = 1'b0;
    out_d.tgt_stop = 1'b0;
    out_d.bp_done_n = 1'b1;
    out_d.bp_done_oe_n = 1'b1;
    upper_d = upper_q;
    lower_d = lower_q;
    xbase_d = xbase_q;
    t_addr_d = t_addr_q;
    t_wr_d = t_wr_q;
    cnt_d = cnt_q;
    lane_d = lane_q;
    sel_d = sel_q;
    ph_d = ph_q;
    served_d = served_q && bp.avalid;
    mem_we = 4'h0;
    mem_wdata = '0;
    case (st_q)
      PBR_IDLE: begin
        if (bp_hit) begin
          // Backplane side wins; a PCI request this cycle is stopped
          out_d.tgt_stop = i_tgt_req;
          t_addr_d = bp.addr;
          t_wr_d = bp.write;
          if (bp.write) begin
            mem_we = 4'hF;
            mem_wdata = bp.data;
          end
          out_d.mst_req = 1'b1;
          out_d.dma_halt = 1'b1;
          out_d.mst_write = bp.write;
          out_d.mst_addr = to_pci(bp.addr, lower_q, xbase_q);
          st_d = PBR_T_REQ;
        end else if (i_tgt_req) begin
          if (pbr_sel_e'(i_tgt_sel) == PBR_SEL_SETUP) begin
            // Setup registers answer at once; unmapped offsets read zero
            out_d.tgt_trdy = 1'b1;
            out_d.tgt_rdata = `PBR_REG_RST;
            case (i_tgt_addr)
              `PBR_OFS_UPPER: begin
                out_d.tgt_rdata = upper_q;
                if (i_tgt_write) upper_d = i_tgt_wdata;
              end
              `PBR_OFS_LOWER: begin
                out_d.tgt_rdata = lower_q;
                if (i_tgt_write) lower_d = i_tgt_wdata;
              end
              `PBR_OFS_XBASE: begin
                out_d.tgt_rdata = xbase_q;
                if (i_tgt_write) xbase_d = i_tgt_wdata;
              end
              default: out_d.tgt_rdata = `PBR_REG_RST;
            endcase
          end else begin
            lane_d = i_tgt_addr[`PBR_LANE_HI:`PBR_LANE_LO];
            sel_d = i_tgt_sel;
            out_d.bp_addr = {i_pci_bp_base, 4'h0, i_tgt_addr[`PBR_OFS_HI:`PBR_WORD_SHIFT]};
            out_d.bp_write = i_tgt_write;
            if (i_tgt_write) begin
              mem_we = 4'(1 << lane_d);
              mem_wdata = {4{i_tgt_wdata}};
              if (pbr_sel_e'(i_tgt_sel) == PBR_SEL_WIN_A ||
                  lane_d == `PBR_LANE_TOP) begin
                out_d.bp_req = 1'b1;
                cnt_d = '0;
                st_d = PBR_I_ARB;
              end else begin
                out_d.tgt_trdy = 1'b1;
              end
            end else if (lane_d == `PBR_LANE_FIRST) begin
              out_d.bp_req = 1'b1;
              cnt_d = '0;
              st_d = PBR_I_ARB;
            end else begin
              // Later lanes come from the word already held
              out_d.tgt_trdy = 1'b1;
              out_d.tgt_rdata = lane_of(mem_word, lane_d);
            end
          end
        end
      end
      PBR_I_ARB: begin
        if (bp_hit || (!bp.gnt && cnt_q == 5'(ARB_LAST))) begin
          // Give up the backplane; the host controller retries
          out_d.tgt_stop = 1'b1;
          out_d.bp_req = 1'b0;
          st_d = PBR_IDLE;
        end else if (bp.gnt) begin
          out_d.bp_avalid = 1'b1;
          out_d.bp_wdata = mem_word;
          st_d = PBR_I_WAIT;
        end else begin
          cnt_d = cnt_q + 5'h1;
        end
      end
      PBR_I_WAIT: begin
        // Local cycle stays open; no target ready until done arrives
        if (!bp.done_n) begin
          out_d.bp_avalid = 1'b0;
          out_d.bp_req = 1'b0;
          if (!out_q.bp_write) begin
            mem_we = 4'hF;
            mem_wdata = bp.data;
          end
          st_d = PBR_I_ANS;
        end
      end
      PBR_I_ANS: begin
        out_d.tgt_trdy = 1'b1;
        out_d.tgt_rdata = lane_of(mem_word, lane_q);
        st_d = PBR_IDLE;
      end
      PBR_T_REQ: begin
        if (i_mst_gnt) begin
          ph_d = 1'b0;
          out_d.mst_wdata = mem_word[63:0];
          st_d = PBR_T_XFER;
        end
      end
      PBR_T_XFER: begin
        if (i_mst_ack) begin
          if (!t_wr_q) begin
            mem_we = ph_q ? 4'hC : 4'h3;
            mem_wdata = {i_mst_rdata, i_mst_rdata};
          end
          if (ph_q) begin
            out_d.mst_req = 1'b0;
            out_d.dma_halt = 1'b0;
            st_d = PBR_T_DONE;
          end else begin
            ph_d = 1'b1;
            out_d.mst_wdata = mem_word[127:64];
          end
        end
      end
      PBR_T_DONE: begin
        out_d.bp_done_n = 1'b0;
        out_d.bp_done_oe_n = 1'b0;
        out_d.bp_rdata = mem_word;
        served_d = 1'b1;
        st_d = PBR_IDLE;
      end
      default: st_d = PBR_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      st_q <= PBR_IDLE;
      out_q <= OUT_RST;
      upper_q <= `PBR_REG_RST;
      lower_q <= `PBR_REG_RST;
      xbase_q <= `PBR_REG_RST;
      t_addr_q <= '0;
      t_wr_q <= 1'b0;
      cnt_q <= '0;
      lane_q <= '0;
      sel_q <= '0;
      ph_q <= 1'b0;
      served_q <= 1'b0;
    end else begin
      st_q <= st_d;
      out_q <= out_d;
      upper_q <= upper_d;
      lower_q <= lower_d;
      xbase_q <= xbase_d;
      t_addr_q <= t_addr_d;
      t_wr_q <= t_wr_d;
      cnt_q <= cnt_d;
      lane_q <= lane_d;
      sel_q <= sel_d;
      ph_q <= ph_d;
      served_q <= served_d;
    end
  end

  // Outputs straight from the output register
  assign o_tgt_trdy = out_q.tgt_trdy;
  assign o_tgt_stop = out_q.tgt_stop;
  assign o_tgt_rdata = out_q.tgt_rdata;
  assign o_mst_req = out_q.mst_req;
  assign o_mst_write = out_q.mst_write;
  assign o_mst_addr = out_q.mst_addr;
  assign o_mst_wdata = out_q.mst_wdata;
  assign o_dma_halt = out_q.dma_halt;
  assign o_bp_req = out_q.bp_req;
  assign o_bp_avalid = out_q.bp_avalid;
  assign o_bp_write = out_q.bp_write;
  assign o_bp_addr = out_q.bp_addr;
  assign o_bp_wdata = out_q.bp_wdata;
  assign o_bp_done_n = out_q.bp_done_n;
  assign o_bp_done_oe_n = out_q.bp_done_oe_n;
  assign o_bp_rdata = out_q.bp_rdata;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  chk_window_hit: assert property ($rose(o_mst_req) |->
    t_addr_q[31:16] >= lower_q[31:16] && t_addr_q[31:16] < upper_q[31:16])
    else $error("target access outside window");
  chk_pci_base: assert property ($rose(o_mst_req) |->
    o_mst_addr[31:20] == xbase_q[31:20]) else $error("PCI base bits wrong");
  chk_word_stride: assert property ($rose(o_mst_req) |->
    o_mst_addr[3:0] == 4'h0) else $error("PCI address not word aligned");
  chk_trdy_coupled: assert property (o_bp_avalid |-> !o_tgt_trdy)
    else $error("target ready during backplane cycle");
  chk_trdy_after_done: assert property ((st_q == PBR_I_WAIT && !bp.done_n) |->
    ##2 o_tgt_trdy) else $error("no target ready after done");
  chk_read_aligned: assert property (($rose(o_bp_req) && !o_bp_write) |->
    lane_q == 2'h0) else $error("backplane read from unaligned lane");
  chk_full_word: assert property (($rose(o_bp_req) && o_bp_write &&
    sel_q == 2'(PBR_SEL_WIN_B)) |-> lane_q == 2'h3) else $error("early full-word start");
  chk_dma_halt: assert property (o_mst_req |-> o_dma_halt)
    else $error("DMA not halted");
  // Stop is a one-cycle pulse in the cycle right after the last arbitration count
  chk_arb_stop: assert property ((st_q == PBR_I_ARB && !bp.gnt && !bp_hit &&
    cnt_q == 5'(ARB_LAST)) |=> o_tgt_stop) else $error("no stop on timeout");
  chk_bp_first: assert property ((st_q == PBR_I_ARB && bp_hit) |->
    ##1 st_q == PBR_IDLE ##1 st_q == PBR_T_REQ) else $error("backplane not served first");
  chk_done_pulse: assert property ($fell(o_bp_done_n) |=> o_bp_done_n)
    else $error("done longer than one cycle");
  chk_done_after: assert property ($fell(o_bp_done_n) |->
    !$past(o_mst_req) && !o_mst_req) else $error("done before burst end");

  cov_init_write: cover property (o_bp_avalid && o_bp_write ##[1:40] o_tgt_trdy);
  cov_init_read: cover property (o_bp_avalid && !o_bp_write ##[1:40] o_tgt_trdy);
  cov_target: cover property ($rose(o_mst_req) ##[2:40] !o_bp_done_n);
  cov_retry: cover property (o_bp_req ##1 o_tgt_stop);
endmodule : pbr_bridge

/* verif/pbr_peer_model.sv */
// Peer board on the backplane: grants our bus, answers as target, starts accesses.
// Assumes it samples the bridge outputs on the same clock the bridge runs on.
`timescale 1ns/1ps
module pbr_peer_model import pbr_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_slow,
  input wire logic i_grant_en,
  input wire logic [127:0] i_rdata,
  input wire logic i_bp_req,
  input wire logic i_bp_avalid,
  input wire logic i_bp_write,
  input wire logic [31:0] i_bp_addr,
  input wire logic [127:0] i_bp_wdata,
  input wire logic i_bp_done_n,
  output pbr_bp_in_s o_bp,
  output logic [31:0] o_seen_addr,
  output logic [127:0] o_seen_data,
  output int o_cycles
);
  logic served;
  int wait_q;

  // Idle backplane: done pulled high, nothing addressed
  initial begin
    o_bp = '0;
    o_bp.done_n = 1'b1;
    served = 1'b0;
    wait_q = 0;
    o_cycles = 0;
    o_seen_addr = '0;
    o_seen_data = '0;
  end

  // Target side: grant on request, answer once per address after one or eight cycles
  always @(posedge i_ref_clk) begin
    o_bp.gnt <= i_bp_req && i_grant_en;
    o_bp.done_n <= 1'b1;
    if (!i_bp_avalid) begin
      wait_q <= 0;
      served <= 1'b0;
      if (served) o_bp.data <= ~o_bp.data; // Released lines must not look held
    end else if (!served) begin
      wait_q <= wait_q + 1;
      if (wait_q == (i_slow ? 8 : 1)) begin
        o_bp.done_n <= 1'b0;
        served <= 1'b1;
        o_cycles <= o_cycles + 1;
        o_seen_addr <= i_bp_addr;
        o_seen_data <= i_bp_wdata;
        if (!i_bp_write) o_bp.data <= i_rdata;
      end
    end
  end

  // Initiator side: hold address and data until done or for at most 60 cycles, then release them
  task automatic access(input logic [31:0] addr, input logic wr, input logic [127:0] d,
                        output logic ok);
    int n;
    ok = 1'b0;
    @(posedge i_ref_clk);
    o_bp.avalid <= 1'b1;
    o_bp.write <= wr;
    o_bp.addr <= addr;
    o_bp.data <= d;
    for (n = 0; n < 60 && !ok; n++) begin
      @(posedge i_ref_clk);
      ok = !i_bp_done_n;
    end
    o_bp.avalid <= 1'b0;
    o_bp.addr <= ~addr;
    o_bp.data <= ~d;
  endtask : access
endmodule : pbr_peer_model

/* verif/pbr_bridge_bench.sv */
// Self-checking bench for the backplane PIO bridge: setup, outbound and inbound paths.
// Assumes the peer model on the backplane; local PCI memory is modelled here.
`timescale 1ns/1ps
`include "pbr_bridge_cfg.svh"
module pbr_bridge_bench import pbr_pkg::*;;
  logic clk, rst, req, wr, mgnt, mack, slow, gen, ok, hbad, gwr, stop_s;
  logic trdy, stop, mreq, mwr, halt, breq, bav, bwr, dn, doe;
  logic [1:0] sel;
  logic [15:0] adr, base;
  logic [31:0] wd, rd, seed, sa, rdat, maddr, baddr, pa, ga, xb;
  logic [63:0] mrd, mwd;
  logic [63:0] mem [2];
  logic [63:0] gw [2];
  logic [127:0] bwd, brd, pd, pr, w;
  pbr_bp_in_s bp;
  int miscompares, total_checks, ph, n, cyc, k, c0;

  pbr_bridge dut_u (.i_ref_clk(clk), .i_reset(rst), .i_tgt_req(req), .i_tgt_sel(sel),
    .i_tgt_write(wr), .i_tgt_addr(adr), .i_tgt_wdata(wd), .o_tgt_trdy(trdy),
    .o_tgt_stop(stop), .o_tgt_rdata(rdat), .i_pci_bp_base(base), .o_mst_req(mreq),
    .i_mst_gnt(mgnt), .o_mst_write(mwr), .o_mst_addr(maddr), .o_mst_wdata(mwd),
    .i_mst_rdata(mrd), .i_mst_ack(mack), .o_dma_halt(halt), .i_bp(bp), .o_bp_req(breq),
    .o_bp_avalid(bav), .o_bp_write(bwr), .o_bp_addr(baddr), .o_bp_wdata(bwd),
    .o_bp_done_n(dn), .o_bp_done_oe_n(doe), .o_bp_rdata(brd));

  pbr_peer_model peer_u (.i_ref_clk(clk), .i_slow(slow), .i_grant_en(gen), .i_rdata(pr),
    .i_bp_req(breq), .i_bp_avalid(bav), .i_bp_write(bwr), .i_bp_addr(baddr),
    .i_bp_wdata(bwd), .i_bp_done_n(dn), .o_bp(bp), .o_seen_addr(pa), .o_seen_data(pd),
    .o_cycles(cyc));

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Local memory: grant follows request, two spaced acks per burst
  always @(posedge clk) begin
    mgnt <= mreq;
    mack <= 1'b0;
    // Halt must track the master request from reset onwards
    if (rst) begin
      hbad <= 1'b0;
    end else if (halt !== mreq) begin
      hbad <= 1'b1;
    end
    if (mack) begin
      gw[ph-1] <= mwd;
      if (ph == 1) ga <= maddr;
      if (ph == 1) gwr <= mwr;
    end
    if (!mreq) ph <= 0;
    else if (mgnt && !mack && ph < 2) begin
      mack <= 1'b1;
      mrd <= mem[ph];
      ph <= ph + 1;
    end
  end

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  task automatic check(input string nm, input logic [127:0] seen, input logic [127:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // One local request pulsed for a single cycle, then wait until the bridge answers with ready or stop
  task automatic tgt(input logic [1:0] s, input logic w_r, input logic [15:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    req <= 1'b1;
    sel <= s;
    wr <= w_r;
    adr <= a;
    wd <= d;
    @(posedge clk);
    req <= 1'b0;
    for (n = 1; n < 200; n++) begin
      @(posedge clk);
      if (trdy === 1'b1 || stop === 1'b1) break;
    end
    rd = rdat;
    stop_s = stop;
  endtask : tgt

  task automatic conclude();
    if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // Hang guard, well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    conclude();
  end

  initial begin
    {req, wr, slow, sel, adr, wd, base} = '0;
    gen = 1'b1;
    rst = 1'b1;
    seed = 32'h6EFD14FB;
    pr = '0;
    mem[0] = '0;
    mem[1] = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    check("done idle", dn, 1'b1);
    // Window bounds with zero low halves so the offset maths stays exact
    xb = rnd();
    tgt(2'd0, 1'b1, `PBR_OFS_UPPER, 32'h0011_0000);
    tgt(2'd0, 1'b1, `PBR_OFS_LOWER, 32'h0010_0000);
    tgt(2'd0, 1'b1, `PBR_OFS_XBASE, xb);
    tgt(2'd0, 1'b0, `PBR_OFS_UPPER, 32'h0);
    check("upper", rd, 32'h0011_0000);
    tgt(2'd0, 1'b0, `PBR_OFS_LOWER, 32'h0);
    check("lower", rd, 32'h0010_0000);
    tgt(2'd0, 1'b0, `PBR_OFS_XBASE, 32'h0);
    check("xbase", rd, xb);
    tgt(2'd0, 1'b0, 16'h0010, 32'h0);
    check("unmapped", rd, 32'h0);
    // Narrow window writes, one per lane, fast and slow peer
    for (k = 0; k < 4; k++) begin
      sa = rnd();
      base <= sa[31:16];
      slow <= k[0];
      c0 = cyc;
      tgt(2'd1, 1'b1, {sa[15:4], k[1:0], 2'b00}, sa ^ 32'h5A5A_0F0F);
      check("a stop", stop_s, 1'b0);
      check("a addr", pa, {sa[31:16], 4'h0, sa[15:4]});
      check("a lane", pd[k*32 +: 32], sa ^ 32'h5A5A_0F0F);
      check("a count", cyc, c0 + 1);
      check("a coupled", n >= 5, 1'b1);
    end
    // Full-word window: only the top lane launches the cycle
    for (k = 0; k < 4; k++) begin
      w[k*32 +: 32] = rnd();
      c0 = cyc;
      tgt(2'd2, 1'b1, {sa[15:4], k[1:0], 2'b00}, w[k*32 +: 32]);
      check("b count", cyc, c0 + (k == 3));
    end
    check("b word", pd, w);
    // Aligned read fetches the word, later lanes come from the buffer
    pr = {rnd(), rnd(), rnd(), rnd()};
    c0 = cyc;
    for (k = 0; k < 4; k++) begin
      tgt(k == 0 ? 2'd1 : 2'd2, 1'b0, {sa[15:4], k[1:0], 2'b00}, 32'h0);
      check("rd lane", rd, pr[k*32 +: 32]);
    end
    check("rd count", cyc, c0 + 1);
    // Grant withheld: the host must be told to retry
    gen <= 1'b0;
    tgt(2'd1, 1'b1, 16'h0000, 32'h0);
    check("arb stop", stop_s, 1'b1);
    check("arb wait", n >= `PBR_ARB_CYCLES, 1'b1);
    // Backplane access during arbitration wins; the local request is stopped
    sa = rnd();
    fork
      tgt(2'd1, 1'b1, 16'h0000, 32'h0);
      peer_u.access({16'h0010, sa[15:0]}, 1'b1, w, ok);
    join
    check("both stop", stop_s, 1'b1);
    check("both hit", ok, 1'b1);
    check("both data", {gw[1], gw[0]}, w);
    gen <= 1'b1;
    repeat (20) @(posedge clk);
    // Inbound accesses from the peer in both directions
    for (k = 0; k < 4; k++) begin
      sa = rnd();
      mem[0] = {rnd(), rnd()};
      mem[1] = {rnd(), rnd()};
      w = {rnd(), rnd(), rnd(), rnd()};
      peer_u.access({16'h0010, sa[15:0]}, k[0], w, ok);
      check("in hit", ok, 1'b1);
      check("done drive", doe, 1'b0);
      check("in addr", ga, {xb[31:20], sa[15:0], 4'h0});
      check("in dir", gwr, k[0]);
      if (k[0]) check("in wdata", {gw[1], gw[0]}, w);
      else check("in rdata", brd, {mem[1], mem[0]});
      @(posedge clk);
      check("done pulse", dn, 1'b1);
      check("done release", doe, 1'b1);
      repeat (4) @(posedge clk);
    end
    // Upper bound is outside, just below the lower bound too
    peer_u.access({16'h0011, sa[15:0]}, 1'b1, w, ok);
    check("miss upper", ok, 1'b0);
    peer_u.access({16'h000F, sa[15:0]}, 1'b1, w, ok);
    check("miss lower", ok, 1'b0);
    check("dma halt", hbad, 1'b0);
    conclude();
  end
endmodule : pbr_bridge_bench
